// ==== core/irq_prio_pkg.sv ====
// irq_prio_pkg: register indices, field layouts, masks and request
// vector numbers shared by the priority/vector register block.
// assumes a 32-bit APB slave with one aligned word per register index.
package irq_prio_pkg;

  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_PRIO     = 6'h09;
  localparam logic [5:0] IDX_BASE     = 6'h0A;
  localparam logic [5:0] IDX_F0_SEL   = 6'h0B;
  localparam logic [5:0] IDX_F0_LOW   = 6'h0C;
  localparam logic [5:0] IDX_F0_HIGH  = 6'h0D;
  localparam logic [5:0] IDX_F1_SEL   = 6'h0E;
  localparam logic [5:0] IDX_F1_LOW   = 6'h0F;
  localparam logic [5:0] IDX_F1_HIGH  = 6'h10;
  localparam logic [5:0] IDX_STATUS   = 6'h20;
  localparam logic [5:0] IDX_MASK     = 6'h21;
  localparam logic [5:0] IDX_ACTIVE   = 6'h22;

  // writable bit masks; all other bits read zero
  localparam logic [15:0] PRIO_WMASK  = 16'hCCCC;
  localparam logic [15:0] BASE_WMASK  = 16'h1FFF;
  localparam logic [15:0] SEL_WMASK   = 16'h007F;
  localparam logic [15:0] LOW_WMASK   = 16'hFFFF;
  localparam logic [15:0] HIGH_WMASK  = 16'h001F;
  localparam logic [15:0] REG_RESET   = 16'h0000;

  // priority field encodings
  localparam logic [1:0] PRIO_OFF     = 2'h0;
  localparam logic [1:0] PRIO_LVL0    = 2'h1;
  localparam logic [1:0] PRIO_LVL1    = 2'h2;
  localparam logic [1:0] PRIO_LVL2    = 2'h3;

  // requests: 0 pwm fault, 1 pwm reload, 2 zero/limit, 3 conversion done
  localparam int NUM_REQ = 4;
  localparam int PRIO_LSB [NUM_REQ] = '{14, 10, 6, 2};
  localparam logic [6:0] REQ_VEC [NUM_REQ] = '{7'h3C, 7'h3D, 7'h3E, 7'h3F};

  // vector field widths
  localparam int BASE_W   = 13;
  localparam int LOWV_W   = 8;
  localparam int VEC_W    = 21;

  // status bits: fast 0 taken, fast 1 taken, normal vector taken
  localparam int ST_W     = 3;
  localparam int ST_F0    = 0;
  localparam int ST_F1    = 1;
  localparam int ST_NORM  = 2;

endpackage : irq_prio_pkg

// ==== core/irq_prio_arbiter.sv ====
// irq_prio_arbiter: picks the winning request among the four inputs.
// assumes priority fields and fast selects come from registers on clk.
`timescale 1ns/10ps
module irq_prio_arbiter
  import irq_prio_pkg::*;
(
  // requests and configuration
  input  wire logic [NUM_REQ-1:0] req,
  input  wire logic [15:0]        prio_reg,
  input  wire logic [6:0]         fast0_num,
  input  wire logic [6:0]         fast1_num,
  // winner
  output logic                    win_valid,
  output logic [1:0]              win_level,
  output logic [6:0]              win_vec,
  output logic                    win_fast0,
  output logic                    win_fast1
);

  // score {enabled, level, fast0, fast1, inverted vector}
  logic [11:0] score [NUM_REQ];
  logic [11:0] best;

  genvar g;
  generate
    for (g = 0; g < NUM_REQ; g++) begin : g_score
      logic [1:0] fld;   // this request's priority field
      logic       en;    // pending and not masked
      assign fld = prio_reg[PRIO_LSB[g] +: 2];
      assign en  = req[g] && (fld != PRIO_OFF);
      // level first, fast beats equal level, lower number wins ties
      assign score[g] = en ? {1'b1, fld - PRIO_LVL0, REQ_VEC[g] == fast0_num,
                              REQ_VEC[g] == fast1_num, ~REQ_VEC[g]} : 12'h000;
    end
  endgenerate

  // maximum search; scores are distinct because vector numbers are
  always_comb begin
    best = 12'h000;
    for (int i = 0; i < NUM_REQ; i++) begin
      if (score[i] > best) begin
        best = score[i];
      end
    end
  end

  // unpack the winning score
  always_comb begin
    win_valid = best[11];
    win_level = best[10:9];
    win_fast0 = best[8];
    win_fast1 = best[7] && !best[8];
    win_vec   = ~best[6:0];
  end

endmodule : irq_prio_arbiter

// ==== core/irq_prio_regs.sv ====
// irq_prio_regs: priority, vector base and fast interrupt registers
// with arbitration and vector presentation to the core.
// assumes APB master on clk; request inputs and core_ack are on clk.
// Function
// - field 00 masks, 01..11 levels 0..2
// - all priority fields reset to masked
// - fault bits 15-14, reload bits 11-10
// - zero/limit bits 7-6, done bits 3-2
// - unimplemented bits read zero, ignore writes
// - 13-bit base gives vector upper bits
// - low eight bits from winning request
// - fast 0 select holds 7-bit number
// - fast 1 select holds 7-bit number
// - fast interrupt presents its direct address
// - fast request beats other level 2
// - fast 0 served before fast 1
// - fast 0 low register 16 bits
// - fast 0 high five bits, 21-bit address
// - fast 1 direct 21-bit address likewise
//
// The APB register port was chosen for this implementation.
`timescale 1ns/10ps
module irq_prio_regs
  import irq_prio_pkg::*;
(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  // peripheral requests
  input  wire logic              pwm_fault_req,
  input  wire logic              pwm_reload_req,
  input  wire logic              converter_zero_limit_req,
  input  wire logic              converter_done_req,
  // core side
  output logic                   irq_req,
  output logic [1:0]             irq_level,
  output logic [VEC_W-1:0]       irq_vector,
  output logic                   irq_fast0,
  output logic                   irq_fast1,
  input  wire logic              core_ack,
  // interrupt line
  output logic                   irq
);

  // stored registers
  logic [15:0]       prio_r;      // priority_pwm_adc_requests
  logic [15:0]       base_r;      // vector_table_base
  logic [15:0]       f0_sel_r;    // fast_irq0_select
  logic [15:0]       f0_low_r;    // fast_irq0_addr_low
  logic [15:0]       f0_high_r;   // fast_irq0_addr_high
  logic [15:0]       f1_sel_r;    // fast_irq1_select
  logic [15:0]       f1_low_r;    // fast_irq1_addr_low
  logic [15:0]       f1_high_r;   // fast_irq1_addr_high
  logic [ST_W-1:0]   status_r;    // sticky events
  logic [ST_W-1:0]   mask_r;      // event enables
  // core outputs
  logic              req_r;
  logic [1:0]        level_r;
  logic [VEC_W-1:0]  vector_r;
  logic              fast0_r;
  logic              fast1_r;
  logic [6:0]        vec_num_r;   // vector number being presented
  // apb read side
  logic [31:0]       prdata_r;
  logic              pslverr_r;
  logic [31:0]       rdata_nxt;
  logic              hit_nxt;
  // decode
  logic [5:0]        idx;         // register index
  logic              wr_en;       // write takes effect now
  logic              setup;       // setup phase of a transfer
  // arbiter results
  logic [NUM_REQ-1:0] reqs;
  logic              win_valid;
  logic [1:0]        win_level;
  logic [6:0]        win_vec;
  logic              win_fast0;
  logic              win_fast1;
  // vectors
  logic [VEC_W-1:0]  fast0_addr;
  logic [VEC_W-1:0]  fast1_addr;
  logic [VEC_W-1:0]  norm_addr;
  logic [ST_W-1:0]   ev_set;      // events this cycle

  // address decode; low two bits and upper bits beyond index ignored
  assign idx   = paddr[7:2];
  assign setup = psel && !penable;
  assign wr_en = psel && penable && pwrite;
  assign pready = 1'b1;

  // masked write helper: only implemented bits can change
  function automatic logic [15:0] wmask(input logic [31:0] d, input logic [15:0] m);
    wmask = d[15:0] & m;
  endfunction : wmask

  // priority register; fields at fixed positions
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prio_r <= REG_RESET;
    end else if (wr_en && idx == IDX_PRIO) begin
      prio_r <= wmask(pwdata, PRIO_WMASK);
    end
  end

  // vector base register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      base_r <= REG_RESET;
    end else if (wr_en && idx == IDX_BASE) begin
      base_r <= wmask(pwdata, BASE_WMASK);
    end
  end

  // fast interrupt select registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      f0_sel_r <= REG_RESET;
      f1_sel_r <= REG_RESET;
    end else if (wr_en) begin
      if (idx == IDX_F0_SEL) begin
        f0_sel_r <= wmask(pwdata, SEL_WMASK);
      end
      if (idx == IDX_F1_SEL) begin
        f1_sel_r <= wmask(pwdata, SEL_WMASK);
      end
    end
  end

  // fast interrupt direct address registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      f0_low_r  <= REG_RESET;
      f0_high_r <= REG_RESET;
      f1_low_r  <= REG_RESET;
      f1_high_r <= REG_RESET;
    end else if (wr_en) begin
      case (idx)
        IDX_F0_LOW:  f0_low_r  <= wmask(pwdata, LOW_WMASK);
        IDX_F0_HIGH: f0_high_r <= wmask(pwdata, HIGH_WMASK);
        IDX_F1_LOW:  f1_low_r  <= wmask(pwdata, LOW_WMASK);
        IDX_F1_HIGH: f1_high_r <= wmask(pwdata, HIGH_WMASK);
        default: ;
      endcase
    end
  end

  // request vector in field order
  assign reqs = {converter_done_req, converter_zero_limit_req,
                 pwm_reload_req, pwm_fault_req};

  // winner selection
  irq_prio_arbiter u_arb (
    .req       (reqs),
    .prio_reg  (prio_r),
    .fast0_num (f0_sel_r[6:0]),
    .fast1_num (f1_sel_r[6:0]),
    .win_valid (win_valid),
    .win_level (win_level),
    .win_vec   (win_vec),
    .win_fast0 (win_fast0),
    .win_fast1 (win_fast1)
  );

  // candidate addresses
  assign fast0_addr = {f0_high_r[4:0], f0_low_r};
  assign fast1_addr = {f1_high_r[4:0], f1_low_r};
  assign norm_addr  = {base_r[BASE_W-1:0], 1'b0, win_vec};

  // registered presentation to the core
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      req_r     <= 1'b0;
      level_r   <= PRIO_OFF;
      vector_r  <= '0;
      fast0_r   <= 1'b0;
      fast1_r   <= 1'b0;
      vec_num_r <= 7'h00;
    end else begin
      req_r     <= win_valid;
      level_r   <= win_level;
      fast0_r   <= win_valid && win_fast0;
      fast1_r   <= win_valid && win_fast1;
      vec_num_r <= win_vec;
      // direct address for fast, table address otherwise
      if (win_fast0) begin
        vector_r <= fast0_addr;
      end else if (win_fast1) begin
        vector_r <= fast1_addr;
      end else begin
        vector_r <= norm_addr;
      end
    end
  end

  assign irq_req    = req_r;
  assign irq_level  = level_r;
  assign irq_vector = vector_r;
  assign irq_fast0  = fast0_r;
  assign irq_fast1  = fast1_r;

  // events: core acknowledges the presented vector
  always_comb begin
    ev_set          = '0;
    ev_set[ST_F0]   = core_ack && req_r && fast0_r;
    ev_set[ST_F1]   = core_ack && req_r && fast1_r;
    ev_set[ST_NORM] = core_ack && req_r && !fast0_r && !fast1_r;
  end

  // sticky status; a new event wins over a write-one clear
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      status_r <= '0;
    end else if (wr_en && idx == IDX_STATUS) begin
      status_r <= (status_r & ~pwdata[ST_W-1:0]) | ev_set;
    end else begin
      status_r <= status_r | ev_set;
    end
  end

  // event mask
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mask_r <= '0;
    end else if (wr_en && idx == IDX_MASK) begin
      mask_r <= pwdata[ST_W-1:0];
    end
  end

  // level interrupt from unmasked sticky bits
  assign irq = |(status_r & mask_r);

  // read mux
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    hit_nxt   = 1'b1;
    case (idx)
      IDX_PRIO:    rdata_nxt[15:0] = prio_r;
      IDX_BASE:    rdata_nxt[15:0] = base_r;
      IDX_F0_SEL:  rdata_nxt[15:0] = f0_sel_r;
      IDX_F0_LOW:  rdata_nxt[15:0] = f0_low_r;
      IDX_F0_HIGH: rdata_nxt[15:0] = f0_high_r;
      IDX_F1_SEL:  rdata_nxt[15:0] = f1_sel_r;
      IDX_F1_LOW:  rdata_nxt[15:0] = f1_low_r;
      IDX_F1_HIGH: rdata_nxt[15:0] = f1_high_r;
      IDX_STATUS:  rdata_nxt[ST_W-1:0] = status_r;
      IDX_MASK:    rdata_nxt[ST_W-1:0] = mask_r;
      // live arbitration state: {req, fast1, fast0, level, number}
      IDX_ACTIVE:  rdata_nxt[11:0] = {req_r, fast1_r, fast0_r, level_r, vec_num_r};
      default:     hit_nxt = 1'b0;
    endcase
  end

  // read data and error captured in the setup phase
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prdata_r  <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else if (setup) begin
      prdata_r  <= pwrite ? 32'h0000_0000 : rdata_nxt;
      pslverr_r <= !hit_nxt;
    end
  end

  assign prdata  = prdata_r;
  assign pslverr = pslverr_r;

  // ---- checks ----

  // priority fields are masked in the cycle after reset
  a_prio_reset: assert property (@(posedge clk)
    $past(rst_n) == 1'b0 |-> prio_r == REG_RESET)
    else $error("priority fields not cleared by reset");

  // all-masked priorities never present a request
  a_mask_blocks: assert property (@(posedge clk) disable iff (!rst_n)
    prio_r == REG_RESET |=> !req_r)
    else $error("masked request reached the core");

  // reserved priority bits and fast 0 high bits 15-5 stay zero
  a_reserved_zero: assert property (@(posedge clk) disable iff (!rst_n)
    (prio_r & ~PRIO_WMASK) == 16'h0000 && f0_high_r[15:5] == 11'h000)
    else $error("reserved bit became set");

  // fault and reload fields follow a write
  a_pwm_fields: assert property (@(posedge clk) disable iff (!rst_n)
    wr_en && idx == IDX_PRIO |=> prio_r[15:14] == $past(pwdata[15:14])
                               && prio_r[11:10] == $past(pwdata[11:10]))
    else $error("pwm priority fields misplaced");

  // converter fields follow a write
  a_adc_fields: assert property (@(posedge clk) disable iff (!rst_n)
    wr_en && idx == IDX_PRIO |=> prio_r[7:6] == $past(pwdata[7:6])
                               && prio_r[3:2] == $past(pwdata[3:2]))
    else $error("converter priority fields misplaced");

  // base register keeps only thirteen bits
  a_base_width: assert property (@(posedge clk) disable iff (!rst_n)
    wr_en && idx == IDX_BASE |=> base_r == ($past(pwdata[15:0]) & BASE_WMASK))
    else $error("vector base width wrong");

  // normal vector is base over winner number
  a_norm_vector: assert property (@(posedge clk) disable iff (!rst_n)
    req_r && !fast0_r && !fast1_r |-> vector_r[VEC_W-1:LOWV_W] == $past(base_r[BASE_W-1:0])
                                    && vector_r[6:0] == vec_num_r)
    else $error("normal vector composition wrong");

  // fast select keeps seven bits
  a_sel_width: assert property (@(posedge clk) disable iff (!rst_n)
    f0_sel_r[15:7] == 9'h000 && f1_sel_r[15:7] == 9'h000)
    else $error("fast select upper bits set");

  // fast 0 presents its direct address
  a_fast0_addr: assert property (@(posedge clk) disable iff (!rst_n)
    fast0_r |-> vector_r == $past(fast0_addr))
    else $error("fast 0 address not presented");

  // fast 1 presents its direct address
  a_fast1_addr: assert property (@(posedge clk) disable iff (!rst_n)
    fast1_r |-> vector_r == $past(fast1_addr))
    else $error("fast 1 address not presented");

  // fast 0 wins whenever it is the arbiter's pick
  a_fast_order: assert property (@(posedge clk) disable iff (!rst_n)
    win_valid && win_fast0 |=> fast0_r && !fast1_r)
    else $error("fast 0 not served first");

  // presented level is the arbitration level
  a_level_follow: assert property (@(posedge clk) disable iff (!rst_n)
    win_valid |=> req_r && level_r == $past(win_level))
    else $error("presented level differs");

endmodule : irq_prio_regs

// ==== dv/core_model.sv ====
// core_model: behavioural processor core that takes presented vectors.
// assumes irq_req is registered on clk; the bench asks for each acknowledge.
`timescale 1ns/10ps
module core_model (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // from the block
  input  wire logic       irq_req,
  // bench control: owe one acknowledge, given after lag cycles
  input  wire logic       take,
  input  wire logic [3:0] lag,
  // to the block
  output logic            core_ack
);
  logic       pend_r;  // acknowledge owed
  logic [3:0] cnt_r;   // cycles still to wait
  // one-cycle acknowledge, only while a vector is presented
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pend_r   <= 1'b0;
      cnt_r    <= 4'h0;
      core_ack <= 1'b0;
    end else begin
      core_ack <= 1'b0;
      if (take) begin
        pend_r <= 1'b1;
        cnt_r  <= lag;
      end else if (pend_r && cnt_r != 4'h0) begin
        cnt_r <= cnt_r - 4'h1;  // slow answer
      end else if (pend_r && irq_req) begin
        core_ack <= 1'b1;
        pend_r   <= 1'b0;
      end
    end
  end
endmodule : core_model

// ==== dv/tb_irq_priority_fast_vector_regs.sv ====
// tb_irq_priority_fast_vector_regs: self-checking bench with a reference model.
// assumes the register block and the core model compile alongside the package.
`timescale 1ns/10ps
module tb_irq_priority_fast_vector_regs
  import irq_prio_pkg::*;
;
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic        irq_req, irq_fast0, irq_fast1, core_ack, irq, take, fa, fb;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, wd;
  logic [1:0]  irq_level, fld;
  logic [20:0] irq_vector, a0, a1;
  logic [3:0]  req_d, lag, rq;
  logic [15:0] prio;
  logic [6:0]  f0, f1;
  logic [12:0] base;
  logic [2:0]  st;         // expected status bits
  logic [25:0] exp_w;      // expected winner word
  logic        err;
  int          error_cnt, num_checks, best, key, w, cnt;
  int          lsb [4] = '{14, 10, 6, 2};  // field positions per request
  logic [15:0] wmask [8] = '{16'hCCCC, 16'h1FFF, 16'h007F, 16'hFFFF,
                             16'h001F, 16'h007F, 16'hFFFF, 16'h001F};
  // clock at 125 MHz
  always #4 clk = ~clk;
  // block under test
  irq_prio_regs DUT (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pwm_fault_req(req_d[0]), .pwm_reload_req(req_d[1]), .converter_zero_limit_req(req_d[2]),
    .converter_done_req(req_d[3]), .irq_req(irq_req), .irq_level(irq_level),
    .irq_vector(irq_vector), .irq_fast0(irq_fast0), .irq_fast1(irq_fast1),
    .core_ack(core_ack), .irq(irq));
  // core on the far side
  core_model u_core (.clk(clk), .rst_n(rst_n), .irq_req(irq_req), .take(take), .lag(lag),
    .core_ack(core_ack));
  // compare and count
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [5:0] idx, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    forever begin
      @(posedge clk);
      if (pready === 1'b1 || n > 50) break;
      n++;
    end
    if (n > 50) error_cnt++;
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // verdict and end of run
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict
  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    print_verdict();
  end
  // main sequence
  initial begin
    clk = 0; rst_n = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    req_d = 0; take = 0; lag = 0; st = 0; error_cnt = 0; num_checks = 0;
    rd = $urandom(41762);
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    // reset values of the eight priority, base and fast interrupt registers
    for (int i = 0; i < 8; i++) begin
      apb(1'b0, IDX_PRIO + 6'(i), 32'h0, rd, err);
      check("reset value", rd, 32'h0);
    end
    // all ones, then random: writable bits kept, reserved read zero
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < 8; i++) begin
        wd = (p == 0) ? 32'hFFFFFFFF : $urandom;
        apb(1'b1, IDX_PRIO + 6'(i), wd, rd, err);
        apb(1'b0, IDX_PRIO + 6'(i), 32'h0, rd, err);
        check("readback", rd, {16'h0, wd[15:0] & wmask[i]});
        case (i)
          1: base = wd[12:0];
          3: a0[15:0] = wd[15:0];
          4: a0[20:16] = wd[4:0];
          6: a1[15:0] = wd[15:0];
          7: a1[20:16] = wd[4:0];
          default: ;
        endcase
      end
    end
    // unmapped index refused
    apb(1'b1, 6'h05, 32'hFFFF, rd, err);
    check("unmapped write err", 32'(err), 32'h1);
    apb(1'b0, 6'h05, 32'h0, rd, err);
    check("unmapped read", rd, 32'h0);
    // random arbitration with acknowledges
    for (int n = 0; n < 60; n++) begin
      prio = 16'($urandom) & 16'hCCCC;
      f0 = ($urandom % 3 == 0) ? 7'h10 : REQ_VEC[$urandom % 4];
      f1 = ($urandom % 3 == 0) ? 7'h10 : REQ_VEC[$urandom % 4];
      rq = 4'($urandom);
      for (int k = 0; k < 4; k++) begin
        if (REQ_VEC[k] == f0 || REQ_VEC[k] == f1) prio[lsb[k]+:2] = 2'b11;
      end
      apb(1'b1, IDX_PRIO, {16'h0, prio}, rd, err);
      apb(1'b1, IDX_F0_SEL, {25'h0, f0}, rd, err);
      apb(1'b1, IDX_F1_SEL, {25'h0, f1}, rd, err);
      req_d <= rq;
      repeat (3) @(posedge clk);
      // reference: level, then fast 0, then fast 1, then lower number
      best = -1;
      w = 0;
      for (int k = 0; k < 4; k++) begin
        fld = prio[lsb[k]+:2];
        key = fld * 16 + (REQ_VEC[k] == f0) * 8 + (REQ_VEC[k] == f1) * 4 + 3 - k;
        if (rq[k] && fld != 2'b00 && key > best) begin
          best = key;
          w = k;
        end
      end
      fld = prio[lsb[w]+:2];
      fa = (REQ_VEC[w] == f0);
      fb = !fa && (REQ_VEC[w] == f1);
      // idle: nothing presented, level zero, table address built from the all-ones number
      exp_w = (best < 0) ? {5'h00, base, 1'b0, 7'h7F}
                         : {1'b1, fld - 2'b01, fa, fb, fa ? a0 : fb ? a1 : {base, 1'b0, REQ_VEC[w]}};
      check("winner", {6'h0, irq_req, irq_level, irq_fast0, irq_fast1, irq_vector}, {6'h0, exp_w});
      if (best >= 0) begin
        // live arbitration word: {req, fast1, fast0, level, number}
        apb(1'b0, IDX_ACTIVE, 32'h0, rd, err);
        check("active", rd, {20'h0, 1'b1, fb, fa, fld - 2'b01, REQ_VEC[w]});
        lag  <= 4'($urandom % 4);
        take <= 1'b1;
        @(posedge clk);
        take <= 1'b0;
        cnt = 0;
        forever begin
          @(posedge clk);
          if (core_ack === 1'b1 || cnt > 20) break;
          cnt++;
        end
        st = st | (fa ? 3'b001 : fb ? 3'b010 : 3'b100);
      end
    end
    req_d <= 4'h0;
    // status, mask and interrupt line
    apb(1'b0, IDX_STATUS, 32'h0, rd, err);
    check("status", rd, {29'h0, st});
    @(posedge clk);
    check("irq masked", 32'(irq), 32'h0);
    apb(1'b1, IDX_MASK, 32'h7, rd, err);
    apb(1'b0, IDX_MASK, 32'h0, rd, err);
    check("mask", rd, 32'h7);
    @(posedge clk);
    check("irq unmasked", 32'(irq), 32'(|st));
    apb(1'b1, IDX_STATUS, {29'h0, st}, rd, err);
    apb(1'b0, IDX_STATUS, 32'h0, rd, err);
    check("status cleared", rd, 32'h0);
    @(posedge clk);
    check("irq cleared", 32'(irq), 32'h0);
    // reset in mid-run must bring programmed fields back to masked
    apb(1'b1, IDX_PRIO, 32'h0000CCCC, rd, err);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, IDX_PRIO, 32'h0, rd, err);
    check("prio after reset", rd, 32'h0);
    print_verdict();
  end
endmodule : tb_irq_priority_fast_vector_regs
